//--- rtl/line_driver_config_command_unit.v
// Configuration command interpreter of a serial-to-bus line driver.
// Assumes a receiver presenting whole command bytes with a one-cycle strobe,
// and a transmitter that takes one response byte with a one-cycle strobe.
// Behaviour
// - Power-up or master reset loads the default value into every parameter.
// - Defaults: slew 000, prog 512 us, pullup 524 ms, load 3 mA, 9.6 kbps.
// - Seven parameters, each a 3-bit code selected by a 3-bit parameter code.
// - Config byte: bit 7 clear, bit 0 set, parameter bits 6-4, value 3-1.
// - Parameter field zero means read of parameter in bits 3-1; nothing changes.
// - Every configuration response byte has bit 0 cleared.
// - Write response echoes command bits 7 to 1.
// - Read response returns value code in bits 3-1, echoes bits 7-4.
// - Write-1 low time 8 to 15 us, applied at flexible speed only.
// - One code sets sample offset and write-0 recovery, 3 to 10 us.
// - Flexible speed with default parameters matches regular speed.
// - Programming pulse 32 to 2048 us doubling; code 111 is indefinite.
// - Strong pullup 16.4 to 1048 ms; 110 dynamic, 111 indefinite.
// - Load sensor enabled only for dynamic strong pullup duration.
// - Termination byte F1h in command mode ends an indefinite pulse.
// - In data mode no pulse can be terminated by command.
// - Baud codes map to 9.6, 19.2, 57.6, 115.2 kbps, repeating.
// - Baud codes 100 to 111 invert the receive line against the pin.
// - Response to a baud change goes out at the new rate.
// - Falling slew control only at flexible speed with non-default code.
`timescale 1ns/1ps
`include "cfg_cmd_defines.vh"

module line_driver_config_command_unit (
    input  wire        sys_clk,
    input  wire        sys_rst,
    input  wire        rx_valid,
    input  wire [7:0]  rx_byte,
    input  wire        command_mode,
    input  wire        flexible_speed,
    input  wire        overdrive_speed,
    input  wire        pulse_active,
    input  wire        polarity_select_pin,
    output reg         tx_valid_reg,
    output reg  [7:0]  tx_byte_reg,
    output reg  [13:0] tx_baud_div_reg,
    output reg  [13:0] rx_baud_div_reg,
    output reg         rxd_invert_reg,
    output reg         data_valid_reg,
    output reg  [7:0]  data_byte_reg,
    output reg         pulse_terminate_reg,
    output reg  [10:0] w1_low_cycles_reg,
    output reg  [10:0] sample_cycles_reg,
    output reg  [10:0] recovery_cycles_reg,
    output reg  [11:0] prog_us_reg,
    output reg         prog_indefinite_reg,
    output reg  [4:0]  spu_shift_reg,
    output reg         spu_dynamic_reg,
    output reg         spu_indefinite_reg,
    output reg         load_sensor_en_reg,
    output reg  [2:0]  load_code_reg,
    output reg         slew_ctrl_en_reg,
    output reg  [2:0]  slew_code_reg
);

    // ********************************************************************
    // States
    // ********************************************************************
    localparam [2:0] ST_IDLE  = 3'h1;
    localparam [2:0] ST_FETCH = 3'h2;
    localparam [2:0] ST_SEND  = 3'h4;

    reg  [2:0] state_reg;
    reg  [2:0] state_next;
    reg  [7:0] cmd_reg;
    reg        store_wr;
    wire [2:0] rd_val;
    wire [20:0] all_vals;

    function is_config;
        input [7:0] b;
        begin
            is_config = !b[`CMD_MSB] && b[`CMD_LSB];
        end
    endfunction

    wire cmd_hit   = rx_valid && command_mode;
    wire cfg_hit   = cmd_hit && is_config(rx_byte) && state_reg == ST_IDLE;
    wire is_read   = rx_byte[`CMD_PAR_HI:`CMD_PAR_LO] == `PAR_CODE_READ;
    wire [2:0] rd_sel = cmd_reg[`CMD_PAR_HI:`CMD_PAR_LO] == `PAR_CODE_READ ?
                        cmd_reg[`CMD_VAL_HI:`CMD_VAL_LO] : `PAR_CODE_READ;

    always @* begin
        store_wr = cfg_hit && !is_read;
    end

    cfg_param_store u_store (
        .sys_clk    (sys_clk),
        .sys_rst    (sys_rst),
        .wr_en      (store_wr),
        .wr_par     (rx_byte[`CMD_PAR_HI:`CMD_PAR_LO]),
        .wr_val     (rx_byte[`CMD_VAL_HI:`CMD_VAL_LO]),
        .rd_par     (rd_sel),
        .rd_val_reg (rd_val),
        .all_vals   (all_vals)
    );

    wire [10:0] w1_c;
    wire [10:0] smp_c;
    wire [10:0] rec_c;
    wire [11:0] prog_us;
    wire        prog_inf;
    wire [4:0]  spu_sh;
    wire        spu_dyn;
    wire        spu_inf;
    wire        slew_en;
    wire [2:0]  slew_c;
    wire [2:0]  load_c;
    wire [13:0] baud_div;
    wire        rx_inv;

    cfg_param_decode u_decode (
        .all_vals        (all_vals),
        .flexible_speed  (flexible_speed),
        .overdrive_speed (overdrive_speed),
        .w1_low_cycles   (w1_c),
        .sample_cycles   (smp_c),
        .recovery_cycles (rec_c),
        .prog_us         (prog_us),
        .prog_indefinite (prog_inf),
        .spu_shift       (spu_sh),
        .spu_dynamic     (spu_dyn),
        .spu_indefinite  (spu_inf),
        .slew_ctrl_en    (slew_en),
        .slew_code       (slew_c),
        .load_code       (load_c),
        .baud_div        (baud_div),
        .rxd_invert      (rx_inv)
    );

    // ********************************************************************
    // Sequencer: take byte, wait one cycle for stored value, send answer
    // ********************************************************************
    always @* begin
        case (state_reg)
            ST_IDLE:  state_next = cfg_hit ? ST_FETCH : ST_IDLE;
            ST_FETCH: state_next = ST_SEND;
            ST_SEND:  state_next = ST_IDLE;
            default:  state_next = ST_IDLE;
        endcase
    end

    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg           <= ST_IDLE;
            cmd_reg             <= 8'h00;
            tx_valid_reg        <= 1'b0;
            tx_byte_reg         <= 8'h00;
            data_valid_reg      <= 1'b0;
            data_byte_reg       <= 8'h00;
            pulse_terminate_reg <= 1'b0;
        end else begin
            state_reg      <= state_next;
            tx_valid_reg   <= 1'b0;
            data_valid_reg <= 1'b0;
            if (cfg_hit) begin
                cmd_reg <= rx_byte;
            end
            // Data mode bytes pass through untouched
            if (rx_valid && !command_mode) begin
                data_valid_reg <= 1'b1;
                data_byte_reg  <= rx_byte;
            end
            // Only in command mode; data mode cannot stop a pulse
            pulse_terminate_reg <= cmd_hit && rx_byte == `TERMINATE_CMD &&
                                   pulse_active;
            if (state_reg == ST_SEND) begin
                // Baud register already updated, so answer uses new rate
                tx_valid_reg <= 1'b1;
                if (cmd_reg[`CMD_PAR_HI:`CMD_PAR_LO] == `PAR_CODE_READ) begin
                    tx_byte_reg <= {cmd_reg[7:4], rd_val, 1'b0};
                end else begin
                    tx_byte_reg <= {cmd_reg[7:1], 1'b0};
                end
            end
        end
    end

    // ********************************************************************
    // Registered settings for the waveform, pulse and serial logic
    // ********************************************************************
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_baud_div_reg     <= `BAUD_DIV_9600;
            rx_baud_div_reg     <= `BAUD_DIV_9600;
            rxd_invert_reg      <= 1'b0;
            w1_low_cycles_reg   <= `DEF_W1_CYC;
            sample_cycles_reg   <= `DEF_SMP_CYC;
            recovery_cycles_reg <= `DEF_SMP_CYC;
            prog_us_reg         <= `DEF_PROG_US;
            prog_indefinite_reg <= 1'b0;
            spu_shift_reg       <= `DEF_SPU_SHIFT;
            spu_dynamic_reg     <= 1'b0;
            spu_indefinite_reg  <= 1'b0;
            load_sensor_en_reg  <= 1'b0;
            load_code_reg       <= `DEF_LOAD;
            slew_ctrl_en_reg    <= 1'b0;
            slew_code_reg       <= `DEF_SLEW;
        end else begin
            tx_baud_div_reg     <= baud_div;
            rx_baud_div_reg     <= baud_div;
            rxd_invert_reg      <= polarity_select_pin ^ rx_inv;
            w1_low_cycles_reg   <= w1_c;
            sample_cycles_reg   <= smp_c;
            recovery_cycles_reg <= rec_c;
            prog_us_reg         <= prog_us;
            prog_indefinite_reg <= prog_inf;
            spu_shift_reg       <= spu_sh;
            spu_dynamic_reg     <= spu_dyn;
            spu_indefinite_reg  <= spu_inf;
            load_sensor_en_reg  <= spu_dyn;
            load_code_reg       <= load_c;
            slew_ctrl_en_reg    <= slew_en;
            slew_code_reg       <= slew_c;
        end
    end

endmodule // line_driver_config_command_unit

//--- rtl/cfg_cmd_defines.vh
// Constants of the configuration command unit: opcodes, field positions,
// parameter codes, default value codes and timing figures.
// Assumes a 100 MHz system clock.
`ifndef CFG_CMD_DEFINES_VH
`define CFG_CMD_DEFINES_VH

// ********************************************************************
// Command byte layout
// ********************************************************************
`define CMD_MSB          7
`define CMD_LSB          0
`define CMD_PAR_HI       6
`define CMD_PAR_LO       4
`define CMD_VAL_HI       3
`define CMD_VAL_LO       1
`define PAR_CODE_READ    3'h0
`define TERMINATE_CMD    8'hF1

// ********************************************************************
// Parameter codes
// ********************************************************************
`define PAR_SLEW         3'h1
`define PAR_PROG         3'h2
`define PAR_SPU          3'h3
`define PAR_WRITE_ONE_LOW_TIME_CODE         3'h4
`define PAR_DSO          3'h5
`define PAR_LOAD         3'h6
`define PAR_BAUD         3'h7

// ********************************************************************
// Default value codes
// ********************************************************************
`define DEF_SLEW         3'h0
`define DEF_PROG         3'h4
`define DEF_SPU          3'h4
`define DEF_WRITE_ONE_LOW_TIME_CODE         3'h0
`define DEF_DSO          3'h0
`define DEF_LOAD         3'h4
`define DEF_BAUD         3'h0

// ********************************************************************
// Special value codes and timing
// ********************************************************************
`define VAL_DYNAMIC      3'h6
`define VAL_INDEFINITE   3'h7
`define BAUD_INV_BIT     2
`define CLK_MHZ          11'h064
`define WRITE_ONE_LOW_TIME_CODE_BASE_US     5'h08
`define DSO_BASE_US      5'h03
`define OD_SLOT_US       5'h01
`define PROG_BASE_US     12'h020
`define DEF_W1_CYC       11'h320
`define DEF_SMP_CYC      11'h12C
`define DEF_PROG_US      12'h200
// Default pullup is 524 ms, five doublings above 16.4 ms
`define DEF_SPU_SHIFT    5'h05
`define SPU_BASE_US      16384
`define SPU_LAST_FINITE  3'h5
`define BAUD_DIV_9600    14'h28B1
`define BAUD_DIV_19200   14'h1458
`define BAUD_DIV_57600   14'h06C8
`define BAUD_DIV_115200  14'h0364

`endif

//--- rtl/cfg_param_store.v
// Seven 3-bit configuration parameter value codes with hard-wired defaults.
// Assumes one write strobe per accepted command; read data is registered.
`timescale 1ns/1ps
`include "cfg_cmd_defines.vh"

module cfg_param_store (
    input  wire       sys_clk,
    input  wire       sys_rst,
    input  wire       wr_en,
    input  wire [2:0] wr_par,
    input  wire [2:0] wr_val,
    input  wire [2:0] rd_par,
    output reg  [2:0] rd_val_reg,
    output wire [20:0] all_vals
);

    reg [2:0] mem_reg [1:7];
    integer i;

    function [2:0] default_of;
        input [2:0] par;
        begin
            case (par)
                `PAR_SLEW: default_of = `DEF_SLEW;
                `PAR_PROG: default_of = `DEF_PROG;
                `PAR_SPU:  default_of = `DEF_SPU;
                `PAR_WRITE_ONE_LOW_TIME_CODE: default_of = `DEF_WRITE_ONE_LOW_TIME_CODE;
                `PAR_DSO:  default_of = `DEF_DSO;
                `PAR_LOAD: default_of = `DEF_LOAD;
                default:   default_of = `DEF_BAUD;
            endcase
        end
    endfunction

    // ********************************************************************
    // Storage
    // ********************************************************************
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (i = 1; i < 8; i = i + 1) begin
                mem_reg[i] <= default_of(i[2:0]);
            end
            rd_val_reg <= 3'h0;
        end else begin
            if (wr_en && wr_par != `PAR_CODE_READ) begin
                mem_reg[wr_par] <= wr_val;
            end
            if (rd_par == `PAR_CODE_READ) begin
                rd_val_reg <= 3'h0;
            end else if (wr_en && wr_par == rd_par) begin
                rd_val_reg <= wr_val;
            end else begin
                rd_val_reg <= mem_reg[rd_par];
            end
        end
    end

    assign all_vals = {mem_reg[7], mem_reg[6], mem_reg[5], mem_reg[4],
                       mem_reg[3], mem_reg[2], mem_reg[1]};

endmodule // cfg_param_store

//--- rtl/cfg_param_decode.v
// Translates stored value codes into the settings the waveform, pulse and
// serial logic consume. Purely combinational; the top registers the outputs.
`timescale 1ns/1ps
`include "cfg_cmd_defines.vh"

module cfg_param_decode (
    input  wire [20:0] all_vals,
    input  wire        flexible_speed,
    input  wire        overdrive_speed,
    output wire [10:0] w1_low_cycles,
    output wire [10:0] sample_cycles,
    output wire [10:0] recovery_cycles,
    output wire [11:0] prog_us,
    output wire        prog_indefinite,
    output wire [4:0]  spu_shift,
    output wire        spu_dynamic,
    output wire        spu_indefinite,
    output wire        slew_ctrl_en,
    output wire [2:0]  slew_code,
    output wire [2:0]  load_code,
    output wire [13:0] baud_div,
    output wire        rxd_invert
);

    wire [2:0] slew = all_vals[2:0];
    wire [2:0] prog = all_vals[5:3];
    wire [2:0] spu  = all_vals[8:6];
    wire [2:0] write_one_low_time_code = all_vals[11:9];
    wire [2:0] dso  = all_vals[14:12];
    wire [2:0] load = all_vals[17:15];
    wire [2:0] baud = all_vals[20:18];

    // Microseconds to clock cycles
    function [10:0] us_to_cyc;
        input [4:0] us;
        begin
            us_to_cyc = {6'h00, us} * `CLK_MHZ;
        end
    endfunction

    // Defaults give 8 us and 3 us, same as regular speed
    assign w1_low_cycles = overdrive_speed ? us_to_cyc(`OD_SLOT_US) :
        flexible_speed ? us_to_cyc(`WRITE_ONE_LOW_TIME_CODE_BASE_US + {2'b00, write_one_low_time_code}) :
        us_to_cyc(`WRITE_ONE_LOW_TIME_CODE_BASE_US);
    assign sample_cycles = overdrive_speed ? us_to_cyc(`OD_SLOT_US) :
        flexible_speed ? us_to_cyc(`DSO_BASE_US + {2'b00, dso}) :
        us_to_cyc(`DSO_BASE_US);
    assign recovery_cycles = (flexible_speed && !overdrive_speed) ?
        us_to_cyc(`DSO_BASE_US + {2'b00, dso}) : us_to_cyc(`DSO_BASE_US);

    assign prog_us = `PROG_BASE_US << prog;
    assign prog_indefinite = (prog == `VAL_INDEFINITE);
    // Doublings above 16.4 ms; the step from code 0 to 1 is two doublings
    assign spu_shift = {2'b00, spu} + {4'h0, spu != `DEF_SLEW};
    assign spu_dynamic = (spu == `VAL_DYNAMIC);
    assign spu_indefinite = (spu == `VAL_INDEFINITE);
    assign slew_ctrl_en = flexible_speed && (slew != `DEF_SLEW);
    assign slew_code = slew;
    assign load_code = load;
    assign baud_div = (baud[1:0] == 2'h0) ? `BAUD_DIV_9600 :
                      (baud[1:0] == 2'h1) ? `BAUD_DIV_19200 :
                      (baud[1:0] == 2'h2) ? `BAUD_DIV_57600 :
                      `BAUD_DIV_115200;
    assign rxd_invert = baud[`BAUD_INV_BIT];

endmodule // cfg_param_decode

//--- verification/cfg_cmd_chk.sv
// Concurrent checks on the ports of the configuration command unit.
// Assumes the host spaces configuration bytes at least four cycles apart.
`timescale 1ns/1ps
`include "cfg_cmd_defines.vh"

module cfg_cmd_chk (
    input wire       sys_clk,
    input wire       sys_rst,
    input wire       rx_valid,
    input wire [7:0] rx_byte,
    input wire       command_mode,
    input wire       pulse_active,
    input wire       polarity_select_pin,
    input wire       tx_valid_reg,
    input wire [7:0] tx_byte_reg,
    input wire [13:0] tx_baud_div_reg,
    input wire [13:0] rx_baud_div_reg,
    input wire       rxd_invert_reg,
    input wire       data_valid_reg,
    input wire [7:0] data_byte_reg,
    input wire       pulse_terminate_reg,
    input wire       spu_dynamic_reg,
    input wire       spu_indefinite_reg,
    input wire       load_sensor_en_reg,
    input wire       slew_ctrl_en_reg,
    input wire [2:0] slew_code_reg
);
    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    wire cfg_take = rx_valid && command_mode && !rx_byte[7] && rx_byte[0];

    resp_bit_zero_a: assert property (tx_valid_reg |-> !tx_byte_reg[0])
        else $error("response bit 0 set");
    write_echo_a: assert property (cfg_take && rx_byte[6:4] != 3'h0 |-> ##3 tx_valid_reg
        && ((tx_byte_reg ^ $past(rx_byte, 3)) & 8'hFE) == 8'h00) else $error("write echo wrong");
    read_echo_a: assert property (cfg_take && rx_byte[6:4] == 3'h0 |-> ##3 tx_valid_reg
        && ((tx_byte_reg ^ $past(rx_byte, 3)) & 8'hF0) == 8'h00) else $error("read echo wrong");
    data_pass_a: assert property (rx_valid && !command_mode |=> data_valid_reg
        && data_byte_reg == $past(rx_byte) ##2 !tx_valid_reg) else $error("data byte lost");
    term_cmd_a: assert property (rx_valid && command_mode && rx_byte == `TERMINATE_CMD
        && pulse_active |-> ##[1:3] pulse_terminate_reg) else $error("no termination");
    no_term_data_a: assert property (rx_valid && !command_mode
        |-> ##1 !pulse_terminate_reg [*3]) else $error("termination in data mode");
    load_sense_a: assert property (load_sensor_en_reg |-> spu_dynamic_reg
        && !spu_indefinite_reg) else $error("load sensor without dynamic pullup");
    baud_pair_a: assert property (tx_baud_div_reg == rx_baud_div_reg)
        else $error("baud dividers differ");
    slew_default_a: assert property (slew_ctrl_en_reg |-> slew_code_reg != 3'h0)
        else $error("slew control with default code");
    pin_invert_a: assert property ($changed(polarity_select_pin) && !rx_valid
        |=> rxd_invert_reg != $past(rxd_invert_reg)) else $error("polarity not followed");
    tx_rate_a: assert property (tx_valid_reg |-> $stable(tx_baud_div_reg))
        else $error("rate moved under response");

    cover property (cfg_take && rx_byte[6:4] == 3'h7);
    cover property (pulse_terminate_reg);
    cover property (data_valid_reg);
endmodule // cfg_cmd_chk

bind line_driver_config_command_unit cfg_cmd_chk u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .command_mode(command_mode),
    .pulse_active(pulse_active), .polarity_select_pin(polarity_select_pin),
    .tx_valid_reg(tx_valid_reg), .tx_byte_reg(tx_byte_reg), .tx_baud_div_reg(tx_baud_div_reg),
    .rx_baud_div_reg(rx_baud_div_reg), .rxd_invert_reg(rxd_invert_reg),
    .data_valid_reg(data_valid_reg), .data_byte_reg(data_byte_reg),
    .pulse_terminate_reg(pulse_terminate_reg), .spu_dynamic_reg(spu_dynamic_reg),
    .spu_indefinite_reg(spu_indefinite_reg), .load_sensor_en_reg(load_sensor_en_reg),
    .slew_ctrl_en_reg(slew_ctrl_en_reg), .slew_code_reg(slew_code_reg));

//--- verification/host_uart_model.sv
// Host side: builds command bytes, sends them whole, counts responses.
// Assumes one byte per send, launched on a falling clock edge.
`timescale 1ns/1ps

module host_uart_model (
    input  wire       sys_clk,
    input  wire       tx_valid_reg,
    input  wire [7:0] tx_byte_reg,
    output reg        rx_valid,
    output reg  [7:0] rx_byte
);
    integer   resp_count;
    reg [7:0] last_resp;
    initial begin
        rx_valid = 1'b0;
        rx_byte = 8'h00;
        resp_count = 0;
        last_resp = 8'h00;
    end
    always @(posedge sys_clk) begin
        if (tx_valid_reg === 1'b1) begin
            resp_count <= resp_count + 1;
            last_resp <= tx_byte_reg;
        end
    end
    function [7:0] wr_cmd(input [2:0] p, input [2:0] v);
        wr_cmd = {1'b0, p, v, 1'b1};
    endfunction
    function [7:0] rd_cmd(input [2:0] p);
        rd_cmd = {4'h0, p, 1'b1};
    endfunction
    task send(input [7:0] b);
        begin
            @(negedge sys_clk);
            rx_byte = b;
            rx_valid = 1'b1;
            @(negedge sys_clk);
            rx_valid = 1'b0;
            // Stale byte inverted so nothing relies on a held value
            rx_byte = ~b;
        end
    endtask
endmodule // host_uart_model

//--- verification/line_driver_config_command_unit_bench.sv
// Self-checking bench for the configuration command unit.
// Assumes the host model drives the receive side; no serial timing modelled.
`timescale 1ns/1ps

module line_driver_config_command_unit_bench;
    reg sys_clk, sys_rst, command_mode, flexible_speed, overdrive_speed;
    reg pulse_active, polarity_select_pin, seen;
    wire rx_valid, tx_valid_reg, rxd_invert_reg, data_valid_reg, pulse_terminate_reg;
    wire prog_indefinite_reg, spu_dynamic_reg, spu_indefinite_reg, load_sensor_en_reg;
    wire slew_ctrl_en_reg;
    wire [7:0] rx_byte, tx_byte_reg, data_byte_reg;
    wire [13:0] tx_baud_div_reg, rx_baud_div_reg;
    wire [10:0] w1_low_cycles_reg, sample_cycles_reg, recovery_cycles_reg;
    wire [11:0] prog_us_reg;
    wire [4:0] spu_shift_reg;
    wire [2:0] load_code_reg, slew_code_reg;
    integer err_count, comparisons, p, v;

    line_driver_config_command_unit u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .rx_valid(rx_valid), .rx_byte(rx_byte), .command_mode(command_mode),
        .flexible_speed(flexible_speed), .overdrive_speed(overdrive_speed),
        .pulse_active(pulse_active), .polarity_select_pin(polarity_select_pin),
        .tx_valid_reg(tx_valid_reg), .tx_byte_reg(tx_byte_reg),
        .tx_baud_div_reg(tx_baud_div_reg), .rx_baud_div_reg(rx_baud_div_reg),
        .rxd_invert_reg(rxd_invert_reg), .data_valid_reg(data_valid_reg),
        .data_byte_reg(data_byte_reg), .pulse_terminate_reg(pulse_terminate_reg),
        .w1_low_cycles_reg(w1_low_cycles_reg), .sample_cycles_reg(sample_cycles_reg),
        .recovery_cycles_reg(recovery_cycles_reg), .prog_us_reg(prog_us_reg),
        .prog_indefinite_reg(prog_indefinite_reg), .spu_shift_reg(spu_shift_reg),
        .spu_dynamic_reg(spu_dynamic_reg), .spu_indefinite_reg(spu_indefinite_reg),
        .load_sensor_en_reg(load_sensor_en_reg), .load_code_reg(load_code_reg),
        .slew_ctrl_en_reg(slew_ctrl_en_reg), .slew_code_reg(slew_code_reg));
    host_uart_model u_host (.sys_clk(sys_clk), .tx_valid_reg(tx_valid_reg),
        .tx_byte_reg(tx_byte_reg), .rx_valid(rx_valid), .rx_byte(rx_byte));

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task check(input [31:0] got, input [31:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("ERROR t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task report_and_stop;
        begin
            if (err_count == 0 && comparisons > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    // Response lands three cycles after the take; one spare cycle allowed
    task cfg(input [7:0] b, input [7:0] exp);
        integer n;
        begin
            n = u_host.resp_count;
            u_host.send(b);
            repeat (4) @(negedge sys_clk);
            check(u_host.resp_count - n, 16'h0001);
            check(u_host.last_resp, exp);
        end
    endtask
    task term(input [7:0] b);
        begin
            seen = 1'b0;
            u_host.send(b);
            repeat (3) begin
                if (pulse_terminate_reg === 1'b1) seen = 1'b1;
                @(negedge sys_clk);
            end
        end
    endtask
    task chk_par(input [2:0] q, input [2:0] c);
        reg [13:0] d;
        begin
            d = c[1] ? (c[0] ? 14'h0364 : 14'h06C8) : (c[0] ? 14'h1458 : 14'h28B1);
            case (q)
                3'h1: check({slew_ctrl_en_reg, slew_code_reg}, {c != 3'h0, c});
                3'h2: check({prog_indefinite_reg, prog_us_reg & {12{c != 3'h7}}},
                    (c == 3'h7) ? 16'h1000 : 12'h020 << c);
                3'h3: check({spu_dynamic_reg, spu_indefinite_reg, load_sensor_en_reg,
                    spu_shift_reg}, {c == 3'h6, c == 3'h7, c == 3'h6,
                    {2'h0, c} + {4'h0, c != 3'h0}});
                3'h4: check(w1_low_cycles_reg, (11'h008 + c) * 11'h064);
                3'h5: check({sample_cycles_reg, recovery_cycles_reg} ^
                    {2{(11'h003 + c) * 11'h064}}, 22'h000000);
                3'h6: check(load_code_reg, c);
                default: check({rxd_invert_reg, tx_baud_div_reg},
                    {polarity_select_pin ^ c[2], d});
            endcase
        end
    endtask
    // Defaults packed three bits per parameter code, code 1 lowest
    task defaults;
        begin
            check(tx_baud_div_reg, 14'h28B1);
            check({w1_low_cycles_reg, sample_cycles_reg}, {11'h320, 11'h12C});
            check({recovery_cycles_reg, prog_us_reg}, {11'h12C, 12'h200});
            check({spu_shift_reg, load_code_reg, slew_code_reg}, {5'h05, 3'h4, 3'h0});
            for (p = 1; p < 8; p = p + 1)
                cfg(u_host.rd_cmd(p[2:0]), {4'h0, 3'(21'h020120 >> (3 * p - 3)), 1'b0});
        end
    endtask

    // ****************************************************************
    // Sequence
    // ****************************************************************
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_count = err_count + 1;
        report_and_stop;
    end
    initial begin
        {sys_rst, command_mode} = 2'h3;
        {flexible_speed, overdrive_speed, pulse_active, polarity_select_pin} = 4'h0;
        err_count = 0;
        comparisons = 0;
        repeat (4) @(negedge sys_clk);
        sys_rst = 1'b0;
        defaults;
        flexible_speed = 1'b1;
        repeat (2) @(negedge sys_clk);
        defaults;
        for (p = 1; p < 8; p = p + 1) begin
            for (v = 0; v < 8; v = v + 1) begin
                cfg(u_host.wr_cmd(p[2:0], v[2:0]), {1'b0, p[2:0], v[2:0], 1'b0});
                chk_par(p[2:0], v[2:0]);
                cfg(u_host.rd_cmd(p[2:0]), {4'h0, v[2:0], 1'b0});
                chk_par(p[2:0], v[2:0]);
            end
        end
        polarity_select_pin = 1'b1;
        repeat (2) @(negedge sys_clk);
        check(rxd_invert_reg, 16'h0000);
        flexible_speed = 1'b0;
        repeat (2) @(negedge sys_clk);
        check({w1_low_cycles_reg, slew_ctrl_en_reg}, {11'h320, 1'b0});
        overdrive_speed = 1'b1;
        repeat (2) @(negedge sys_clk);
        check({w1_low_cycles_reg, sample_cycles_reg}, {11'h064, 11'h064});
        check(recovery_cycles_reg, 11'h12C);
        overdrive_speed = 1'b0;
        pulse_active = 1'b1;
        term(8'hF1);
        check(seen, 16'h0001);
        command_mode = 1'b0;
        term(8'hF1);
        check(seen, 16'h0000);
        u_host.send(u_host.wr_cmd(3'h6, 3'h1));
        repeat (4) @(negedge sys_clk);
        check(load_code_reg, 3'h7);
        {command_mode, pulse_active} = 2'h2;
        sys_rst = 1'b1;
        repeat (2) @(negedge sys_clk);
        sys_rst = 1'b0;
        defaults;
        cfg(u_host.wr_cmd(3'h1, 3'h4), 8'h18);
        report_and_stop;
    end
endmodule // line_driver_config_command_unit_bench
